/* File: hdl/sadc_seq.sv */
// Serial ADC/DAC sequencer and its sample FIFO
`include "sadc_params.svh"
`default_nettype none

// Sample FIFO between the front end and the serializer
module sadc_fifo #(
  parameter int W = 12,
  parameter int D = 16
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  // Fill side
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  // Drain side
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr;
  logic [AW-1:0] rd;
  logic [AW-1:0] next_wr;
  logic [AW-1:0] next_rd;
  logic [AW:0]   cnt;
  logic [AW:0]   next_cnt;
  logic          full;
  logic          next_full;
  logic          empty;
  logic          next_empty;
  logic          push;
  logic          pop;

  // Pointers and fill level
  always_comb begin
    push       = in_valid && !full;
    pop        = out_ready && !empty;
    next_wr    = push ? wr + 1'b1 : wr;
    next_rd    = pop ? rd + 1'b1 : rd;
    next_cnt   = cnt + push - pop;
    next_full  = next_cnt == (AW + 1)'(D);
    next_empty = next_cnt == '0;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wr    <= '0;
      rd    <= '0;
      cnt      <= '0;
      full     <= 1'b0;
      in_ready <= 1'b1;
      empty    <= 1'b1;
    end else begin
      wr       <= next_wr;
      rd       <= next_rd;
      cnt      <= next_cnt;
      full     <= next_full;
      in_ready <= !next_full;
      empty    <= next_empty;
    end
  end

  // Storage write
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr] <= in_data;
    end
  end

  // Flags straight from registers, ready kept as its own flop
  assign out_valid = !empty;
  assign out_data  = mem[rd];
endmodule : sadc_fifo

// Contract
// - Clock pin tied low selects internal oscillator, else external clock drives ADC.
// - Conversion lasts 19 or 20 rising ADC clock edges.
// - Start under 30 ns before a rising edge gives 20 edges.
// - Noncontinuous internal clock always gives exactly 19 edges.
// - Receive clock follows selected ADC clock, may stop after conversion.
// - Start rising edge holds the sampler and begins conversion together.
// - DAC latch takes input latch on load strobe falling edge.
// - Codes are 12-bit two's complement, step is full scale over 4096.
// - DAC code 000 zero, 7FF just below half, 800 negative half.
// - Six serial pins: clock, frame, data for receive and transmit.
// - Result word: four zeros, 12 bits MSB first, frame low at start.
// - Host sends 16 bits; first four dropped, twelve kept MSB first.
// - Load held low updates on sixteenth edge; mid-transfer strobe changes do not.
// - Clock mode low stops receive clock after word; high runs continuously.
module sadc_seq
  import sadc_pkg::*;
(
  // Clock and reset
  input  wire logic     sys_clk,
  input  wire logic     rstn,
  // ADC clock pin, strap and clock mode
  input  wire logic     adc_clk_pin,
  input  wire logic     clk_tied_vss,
  input  wire logic     rclk_continuous,
  // Conversion start and sampler
  input  wire logic     conversion_start_strobe,
  output logic          track_hold,
  // Converted codes from the front end
  input  wire sadc_code_t code_in,
  input  wire logic     code_valid,
  output logic          code_ready,
  // Receive serial port, open-drain
  output sadc_rx_t      rx_o,
  output sadc_rx_t      rx_oe,
  // Transmit serial port and load strobe
  input  wire sadc_tx_t tx_in,
  input  wire logic     dac_load_strobe,
  // DAC latch
  output sadc_code_t    dac_code
);
  localparam logic [4:0] OSC_HALF = 5'(`SADC_OSC_HALF_CYC);
  localparam logic [4:0] SETUP    = 5'(`SADC_SETUP_CYC);
  localparam logic [4:0] EDGES    = 5'(`SADC_CONV_EDGES);
  localparam logic [4:0] WBITS    = 5'(`SADC_WORD_BITS);
  localparam logic [4:0] LAST     = 5'(`SADC_WORD_BITS - 1);

  logic [7:0]  s1;
  logic [7:0]  s2;
  logic        ext_clk, use_osc, cont, cs;
  logic        t_clk, t_fs, t_dt, ld;
  logic        prev_adc, prev_cs, prev_transmit_serial_clock, prev_tfs, prev_ld;
  logic        adc_lvl, adc_rise, cs_rise;
  logic        transmit_serial_clock_fall, tfs_fall, ld_fall, ld_rise;
  logic [4:0]  osc_cnt, next_osc_cnt;
  logic        osc_lvl, next_osc_lvl;
  sadc_state_t state, next_state;
  logic [4:0]  edge_cnt, next_edge_cnt;
  logic [4:0]  since, next_since;
  logic        skipped, next_skipped;
  logic [15:0] shreg, next_shreg;
  logic        next_hold;
  sadc_rx_t    next_rx_oe;
  logic        pop;
  logic        fifo_valid;
  sadc_code_t  fifo_data;
  logic        dac_active, next_dac_active;
  logic [4:0]  dac_cnt, next_dac_cnt;
  logic [11:0] dac_sh, next_dac_sh;
  sadc_code_t  in_latch, next_in_latch;
  sadc_code_t  next_dac_code;
  logic        held, next_held;

  // Two-flop synchronisers on every pin, reset to idle pin levels so no false edge follows reset
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s1 <= 8'h0D;
      s2 <= 8'h0D;
    end else begin
      s1 <= {adc_clk_pin, clk_tied_vss, rclk_continuous, conversion_start_strobe,
             tx_in.sclk, tx_in.frame_n, tx_in.data, dac_load_strobe};
      s2 <= s1;
    end
  end
  assign {ext_clk, use_osc, cont, cs, t_clk, t_fs, t_dt, ld} = s2;

  // Edge history of synchronised levels
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prev_adc  <= 1'b0;
      prev_cs   <= 1'b0;
      prev_transmit_serial_clock <= 1'b1;
      prev_tfs  <= 1'b1;
      prev_ld   <= 1'b1;
    end else begin
      prev_adc  <= adc_lvl;
      prev_cs   <= cs;
      prev_transmit_serial_clock <= t_clk;
      prev_tfs  <= t_fs;
      prev_ld   <= ld;
    end
  end

  // Clock source select and edge detection
  assign adc_lvl   = use_osc ? osc_lvl : ext_clk;
  assign adc_rise  = adc_lvl && !prev_adc;
  assign cs_rise   = cs && !prev_cs;
  assign transmit_serial_clock_fall = prev_transmit_serial_clock && !t_clk;
  assign tfs_fall  = prev_tfs && !t_fs;
  assign ld_fall   = prev_ld && !ld;
  assign ld_rise   = !prev_ld && ld;

  // Internal oscillator, parked low between noncontinuous conversions
  always_comb begin
    next_osc_cnt = osc_cnt;
    next_osc_lvl = osc_lvl;
    if (!cont && state == SADC_IDLE && !cs_rise) begin
      next_osc_cnt = '0;
      next_osc_lvl = 1'b0;
    end else if (osc_cnt == OSC_HALF - 5'h01) begin
      next_osc_cnt = '0;
      next_osc_lvl = !osc_lvl;
    end else begin
      next_osc_cnt = osc_cnt + 5'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      osc_cnt <= '0;
      osc_lvl <= 1'b0;
    end else begin
      osc_cnt <= next_osc_cnt;
      osc_lvl <= next_osc_lvl;
    end
  end

  // Conversion sequencer and result serializer
  always_comb begin
    next_state    = state;
    next_edge_cnt = edge_cnt;
    next_since    = since;
    next_skipped  = skipped;
    next_shreg    = shreg;
    pop           = 1'b0;
    unique case (state)
      SADC_IDLE: begin
        if (cs_rise) begin
          next_state    = SADC_CONV;
          next_edge_cnt = '0;
          next_since    = 5'h01;
          next_skipped  = adc_rise;
          next_shreg    = {4'h0, fifo_valid ? fifo_data : 12'h000};
          pop           = 1'b1;
        end
      end
      SADC_CONV: begin
        if (since != SETUP) begin
          next_since = since + 5'h01;
        end
        if (adc_rise) begin
          if (edge_cnt == '0 && !skipped && since < SETUP) begin
            next_skipped = 1'b1;
          end else begin
            next_edge_cnt = edge_cnt + 5'h01;
            if (edge_cnt != '0) begin
              next_shreg = {shreg[14:0], 1'b0};
            end
          end
        end
        if (next_edge_cnt == EDGES) begin
          next_state = SADC_IDLE;
        end
      end
    endcase
    next_hold          = next_state == SADC_CONV;
    next_rx_oe.frame_n = next_state == SADC_CONV && next_edge_cnt <= WBITS;
    next_rx_oe.data    = next_rx_oe.frame_n && !next_shreg[15];
    next_rx_oe.sclk    = (cont || next_state == SADC_CONV) && !adc_lvl;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state      <= SADC_IDLE;
      edge_cnt   <= '0;
      since      <= '0;
      skipped    <= 1'b0;
      shreg      <= 16'h0000;
      track_hold <= 1'b0;
      rx_oe      <= '0;
    end else begin
      state      <= next_state;
      edge_cnt   <= next_edge_cnt;
      since      <= next_since;
      skipped    <= next_skipped;
      shreg      <= next_shreg;
      track_hold <= next_hold;
      rx_oe      <= next_rx_oe;
    end
  end

  // Open-drain pins only ever pull low
  assign rx_o = '0;

  // Codes wait here until a conversion takes one
  sadc_fifo #(
    .W (`SADC_CODE_BITS),
    .D (`SADC_FIFO_DEPTH)
  ) i_sadc_fifo (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .in_data   (code_in),
    .in_valid  (code_valid),
    .in_ready  (code_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (pop)
  );

  // DAC shift-in, input latch and DAC latch
  always_comb begin
    next_dac_active = dac_active;
    next_dac_cnt    = dac_cnt;
    next_dac_sh     = dac_sh;
    next_in_latch   = in_latch;
    next_dac_code   = dac_code;
    next_held       = held;
    if (tfs_fall) begin
      next_dac_active = 1'b1;
      next_dac_cnt    = '0;
      next_held       = !ld;
    end else if (dac_active) begin
      if (ld_rise) begin
        next_held = 1'b0;
      end
      if (transmit_serial_clock_fall) begin
        next_dac_sh  = {dac_sh[10:0], t_dt};
        next_dac_cnt = dac_cnt + 5'h01;
        if (dac_cnt == LAST) begin
          next_dac_active = 1'b0;
          next_in_latch   = {dac_sh[10:0], t_dt};
          if (held && !ld) begin
            next_dac_code = {dac_sh[10:0], t_dt};
          end
        end
      end
    end
    if (ld_fall && !dac_active) begin
      next_dac_code = in_latch;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dac_active <= 1'b0;
      dac_cnt    <= '0;
      dac_sh     <= 12'h000;
      in_latch   <= 12'h000;
      dac_code   <= 12'h000;
      held       <= 1'b0;
    end else begin
      dac_active <= next_dac_active;
      dac_cnt    <= next_dac_cnt;
      dac_sh     <= next_dac_sh;
      in_latch   <= next_in_latch;
      dac_code   <= next_dac_code;
      held       <= next_held;
    end
  end

  // Checks on conversion and DAC behaviour
  property p_hold_on_start;
    @(posedge sys_clk) disable iff (!rstn)
      (state == SADC_IDLE && cs_rise) |=> track_hold && rx_oe.frame_n;
  endproperty
  a_hold_on_start: assert property (p_hold_on_start)
    else $error("sampler not held at conversion start");

  property p_lead_zeros;
    @(posedge sys_clk) disable iff (!rstn)
      (state == SADC_CONV && edge_cnt <= 5'h03) |=> rx_oe.data && rx_oe.frame_n;
  endproperty
  a_lead_zeros: assert property (p_lead_zeros)
    else $error("leading zero not driven");

  property p_conv_end;
    @(posedge sys_clk) disable iff (!rstn)
      (state == SADC_CONV && next_state == SADC_IDLE) |-> adc_rise && edge_cnt == 5'h12;
  endproperty
  a_conv_end: assert property (p_conv_end)
    else $error("conversion ended at wrong edge");

  property p_far_edge_counts;
    @(posedge sys_clk) disable iff (!rstn)
      (state == SADC_CONV && adc_rise && edge_cnt == '0 && !skipped && since >= SETUP)
        |=> edge_cnt == 5'h01 && !skipped;
  endproperty
  a_far_edge_counts: assert property (p_far_edge_counts)
    else $error("edge outside setup window skipped");

  property p_nc_internal;
    @(posedge sys_clk) disable iff (!rstn)
      (use_osc && !cont && state == SADC_IDLE && cs_rise) |=> (!skipped && !adc_rise) [*3];
  endproperty
  a_nc_internal: assert property (p_nc_internal)
    else $error("noncontinuous conversion not 19 edges");

  property p_rclk_stop;
    @(posedge sys_clk) disable iff (!rstn)
      (!cont && state == SADC_IDLE && !cs_rise) |=> !rx_oe.sclk;
  endproperty
  a_rclk_stop: assert property (p_rclk_stop)
    else $error("receive clock runs while stopped");

  property p_rclk_cont;
    @(posedge sys_clk) disable iff (!rstn)
      (cont && !adc_lvl) |=> rx_oe.sclk;
  endproperty
  a_rclk_cont: assert property (p_rclk_cont)
    else $error("continuous receive clock missing");

  property p_dac_load_strobe_load;
    @(posedge sys_clk) disable iff (!rstn)
      (ld_fall && !dac_active) |=> dac_code == $past(in_latch);
  endproperty
  a_dac_load_strobe_load: assert property (p_dac_load_strobe_load)
    else $error("DAC latch not loaded on strobe");

  property p_sixteenth;
    @(posedge sys_clk) disable iff (!rstn)
      (dac_active && !tfs_fall && transmit_serial_clock_fall && dac_cnt == LAST && held && !ld && !ld_rise)
        |=> dac_code[0] == $past(t_dt) && dac_code[11:1] == $past(dac_sh[10:0]);
  endproperty
  a_sixteenth: assert property (p_sixteenth)
    else $error("no update on sixteenth edge");

  property p_mid_strobe;
    @(posedge sys_clk) disable iff (!rstn)
      (dac_active && !tfs_fall && ld_fall && !transmit_serial_clock_fall) |=> $stable(dac_code);
  endproperty
  a_mid_strobe: assert property (p_mid_strobe)
    else $error("DAC latch changed mid-transfer");
endmodule : sadc_seq
`default_nettype wire

/* File: hdl/sadc_params.svh */
// Constants for the serial converter sequencer
`default_nettype none
`ifndef SADC_PARAMS_SVH
`define SADC_PARAMS_SVH
`define SADC_CLK_NS 10
`define SADC_OSC_HALF_NS 250
`define SADC_OSC_HALF_CYC (`SADC_OSC_HALF_NS / `SADC_CLK_NS)
`define SADC_SETUP_NS 30
`define SADC_SETUP_CYC ((`SADC_SETUP_NS + `SADC_CLK_NS - 1) / `SADC_CLK_NS)
`define SADC_CONV_EDGES 19
`define SADC_WORD_BITS 16
`define SADC_LEAD_BITS 4
`define SADC_CODE_BITS 12
`define SADC_FIFO_DEPTH 16
`endif
`default_nettype wire

/* File: hdl/sadc_pkg.sv */
// Types shared by the converter sequencer
`include "sadc_params.svh"
`default_nettype none
package sadc_pkg;
  typedef enum logic {
    SADC_IDLE = 1'b0,
    SADC_CONV = 1'b1
  } sadc_state_t;

  // Transmit serial pins, as seen from the device
  typedef struct packed {
    logic sclk;
    logic frame_n;
    logic data;
  } sadc_tx_t;

  // Receive serial pins, open-drain
  typedef struct packed {
    logic sclk;
    logic frame_n;
    logic data;
  } sadc_rx_t;

  typedef logic [`SADC_CODE_BITS-1:0] sadc_code_t;
endpackage : sadc_pkg
`default_nettype wire

/* File: testbench/sadc_host_model.sv */
// Host side model: transmit port, load strobe and receive word capture
`default_nettype none
module sadc_host_model
  import sadc_pkg::*;
(
  // Clock
  input  wire logic      sys_clk,
  // Receive wires after pull-ups
  input  wire sadc_rx_t  rx_line,
  // Transmit pins and load strobe
  output sadc_tx_t       tx,
  output logic           dac_load_strobe,
  // Captured receive words
  output logic [15:0]    rx_word,
  output logic [7:0]     rx_count
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [15:0] shift;
  int          nbits;

  // Idle link: clock still and high, frame high
  initial begin
    tx = '{sclk: 1'b1, frame_n: 1'b1, data: 1'b0};
    dac_load_strobe = 1'b1;
    rx_word = 16'h0000;
    rx_count = 8'h00;
    nbits = 0;
  end

  // Data taken on falling receive clock while framed
  always @(negedge rx_line.sclk) begin
    if (rx_line.frame_n === 1'b0) begin
      shift = {shift[14:0], rx_line.data};
      nbits++;
    end
  end

  // Word handed on when the frame returns high
  always @(posedge rx_line.frame_n) begin
    if (nbits > 0) begin
      rx_word = shift;
      rx_count++;
      nbits = 0;
    end
  end

  // Load strobe moves off the sampling edge
  task automatic set_ld(input logic v);
    @(negedge sys_clk);
    dac_load_strobe = v;
  endtask : set_ld

  // Sixteen bits valid at falling clock; act 1 raises, act 2 drops the strobe mid-word
  task automatic send(input logic [15:0] w, input int act);
    #1;
    tx.frame_n = 1'b0;
    #62.5;
    for (int b = 15; b >= 0; b--) begin
      tx.data = w[b];
      if (b == 8 && act == 1) dac_load_strobe = 1'b1;
      if (b == 8 && act == 2) dac_load_strobe = 1'b0;
      #62.5 tx.sclk = 1'b0;
      #62.5 tx.sclk = 1'b1;
    end
    tx.frame_n = 1'b1;
    tx.data = ~tx.data;
    #250;
  endtask : send
endmodule : sadc_host_model
`default_nettype wire

/* File: testbench/sadc_seq_tb_top.sv */
// Self-checking bench for the converter sequencer
`default_nettype none
module sadc_seq_tb_top
  import sadc_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 100ps;

  logic        sys_clk, rstn, adc_src, adc_clk_pin, clk_tied_vss, rclk_continuous;
  logic        conversion_start_strobe, track_hold, code_valid, code_ready, dac_load_strobe;
  sadc_code_t  code_in, dac_code, dac_q;
  sadc_rx_t    rx_o, rx_oe, rx_line;
  sadc_tx_t    tx;
  logic [15:0] rx_word, q_word[$], q_edge[$], q_dac[$];
  logic [7:0]  rx_count, rxc_q = 8'h00;
  logic        sclk_q, th_q;
  int          n_fail, checks, n_rise, base, tail;

  // System clock, 100 MHz
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // External converter clock, 2 MHz, off the system grid
  initial begin
    adc_src = 1'b0;
    #3;
    forever #250 adc_src = ~adc_src;
  end
  assign adc_clk_pin = adc_src & ~clk_tied_vss;
  assign rx_line     = ~rx_oe | rx_o;

  sadc_seq i_sadc_seq (
    .sys_clk                 (sys_clk),
    .rstn                    (rstn),
    .adc_clk_pin             (adc_clk_pin),
    .clk_tied_vss            (clk_tied_vss),
    .rclk_continuous         (rclk_continuous),
    .conversion_start_strobe (conversion_start_strobe),
    .track_hold              (track_hold),
    .code_in                 (code_in),
    .code_valid              (code_valid),
    .code_ready              (code_ready),
    .rx_o                    (rx_o),
    .rx_oe                   (rx_oe),
    .tx_in                   (tx),
    .dac_load_strobe         (dac_load_strobe),
    .dac_code                (dac_code)
  );

  sadc_host_model i_sadc_host_model (
    .sys_clk         (sys_clk),
    .rx_line         (rx_line),
    .tx              (tx),
    .dac_load_strobe (dac_load_strobe),
    .rx_word         (rx_word),
    .rx_count        (rx_count)
  );

  // Comparison with count of mismatches
  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask : check

  // Verdict and end of run
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  // Result watcher: each result takes the oldest expectation
  always @(posedge sys_clk) begin
    if (rx_line.sclk === 1'b1 && sclk_q === 1'b0) n_rise++;
    if (track_hold === 1'b1 && th_q === 1'b0) base = n_rise;
    if (track_hold === 1'b0 && th_q === 1'b1) tail = 3;
    else if (tail > 0) tail--;
    if (tail == 1) check("edges", q_edge.size() ? q_edge.pop_front() : 16'hXXXX, 16'(n_rise - base));
    if (rx_count !== rxc_q) check("word", q_word.size() ? q_word.pop_front() : 16'hXXXX, rx_word);
    if (rstn === 1'b1 && dac_code !== dac_q) check("dac", q_dac.size() ? q_dac.pop_front() : 16'hXXXX, {4'h0, dac_code});
    sclk_q = rx_line.sclk;
    th_q = track_hold;
    dac_q = dac_code;
    rxc_q = rx_count;
  end

  // One conversion with chosen clock source and start alignment
  task automatic conv(input logic ext, input logic late, input logic [15:0] word);
    int n;
    @(negedge sys_clk);
    clk_tied_vss = ~ext;
    repeat (60) @(negedge sys_clk);
    if (ext) begin
      @(posedge adc_src);
      #(late ? 478 : 100);
    end else begin
      repeat ($urandom % 50) @(negedge sys_clk);
    end
    @(negedge sys_clk);
    q_word.push_back(word);
    q_edge.push_back((ext && late) ? 16'h0014 : 16'h0013);
    conversion_start_strobe = 1'b1;
    repeat (4) @(negedge sys_clk);
    check("hold", 16'h0001, {15'h0, track_hold});
    check("frame", 16'h0000, {15'h0, rx_line.frame_n});
    conversion_start_strobe = 1'b0;
    n = 0;
    while (track_hold !== 1'b0 && n < 3000) begin
      @(negedge sys_clk);
      n++;
    end
    check("busy", 16'h0000, {15'h0, track_hold});
    repeat (200) @(negedge sys_clk);
  endtask : conv

  // Main sequence
  initial begin
    logic [15:0] w;
    sadc_code_t  tbl[4];
    sadc_code_t  fq[$];
    int          b;
    logic [1:0]  mode;
    logic [1:0]  moff;
    rstn = 1'b0;
    clk_tied_vss = 1'b0;
    rclk_continuous = 1'b0;
    conversion_start_strobe = 1'b0;
    code_valid = 1'b0;
    code_in = 12'h000;
    void'($urandom(44));
    repeat (8) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (3) @(negedge sys_clk);
    check("reset", 16'h1000, {rx_oe, code_ready, dac_code});
    // Codes in both load styles
    tbl = '{12'h7FF, 12'h000, 12'h800, {1'b0, 11'($urandom)} | 12'h001};
    for (int k = 0; k < 4; k++) begin
      w = {4'($urandom), tbl[k]};
      if (k % 2 == 0) begin
        i_sadc_host_model.set_ld(1'b0);
        q_dac.push_back({4'h0, tbl[k]});
        i_sadc_host_model.send(w, 0);
      end else begin
        i_sadc_host_model.send(w, 0);
        q_dac.push_back({4'h0, tbl[k]});
        i_sadc_host_model.set_ld(1'b0);
        repeat (5) @(negedge sys_clk);
      end
      i_sadc_host_model.set_ld(1'b1);
      repeat (5) @(negedge sys_clk);
    end
    // Strobe moves mid-word: no update, input latch still loads
    i_sadc_host_model.set_ld(1'b0);
    i_sadc_host_model.send({4'h0, 1'b1, 11'($urandom)}, 1);
    w = {4'hF, 1'b1, 11'($urandom)};
    i_sadc_host_model.send(w, 2);
    i_sadc_host_model.set_ld(1'b1);
    repeat (5) @(negedge sys_clk);
    q_dac.push_back({4'h0, w[11:0]});
    i_sadc_host_model.set_ld(1'b0);
    repeat (5) @(negedge sys_clk);
    i_sadc_host_model.set_ld(1'b1);
    // Fill the sample buffer until it refuses
    for (int i = 0; i < 17; i++) begin
      @(negedge sys_clk);
      code_valid = 1'b1;
      code_in = 12'($urandom);
      if (i == 16) check("full", 16'h0000, {15'h0, code_ready});
      else fq.push_back(code_in);
    end
    @(negedge sys_clk);
    code_valid = 1'b0;
    // Drain through conversions, the last one from an empty buffer
    for (int i = 0; i < 17; i++) begin
      conv(i % 4 < 2, i[0], {4'h0, i < 16 ? fq[i] : 12'h000});
    end
    // Receive clock when idle, every clock mode and source, in fixed rotation from a random first mode
    moff = 2'($urandom);
    for (int m = 0; m < 4; m++) begin
      mode = 2'(m) + moff;
      @(negedge sys_clk);
      rclk_continuous = mode[1];
      clk_tied_vss = mode[0];
      repeat (60) @(negedge sys_clk);
      b = n_rise;
      repeat (400) @(negedge sys_clk);
      check("rclk", mode[1] ? 16'h0008 : 16'h0000, 16'(n_rise - b));
    end
    check("pending", 16'h0000, 16'(q_word.size() + q_edge.size() + q_dac.size()));
    final_report();
  end

  // Watchdog against a hang
  initial begin
    #500000;
    n_fail++;
    final_report();
  end
endmodule : sadc_seq_tb_top
`default_nettype wire
